// file: include/sli_pkg.sv
package sli_pkg;

  // module clock
  localparam int CLK_FREQ_HZ    = 10_000_000;
  // flash half period, in ms
  localparam int BLINK_HALF_MS  = 250;
  // flash half period, in clock cycles
  localparam int BLINK_HALF_CYC = BLINK_HALF_MS * (CLK_FREQ_HZ / 1000);

  // hold counters count flash half periods
  localparam int                HOLD_W               = 3;
  localparam logic [HOLD_W-1:0] LAMP_TEST_HALVES     = 3'h4;
  localparam logic [HOLD_W-1:0] TRAFFIC_HOLD_HALVES  = 3'h3;
  localparam logic [HOLD_W-1:0] COMM_ERR_HOLD_HALVES = 3'h4;

  // repeat counter for the steady error lamp
  localparam int REP_W              = 4;
  localparam int APP_STEADY_REPEATS = 4;

  // register port
  localparam int                ADDR_W        = 8;
  localparam int                DATA_W        = 32;
  localparam logic [ADDR_W-1:0] ADDR_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STATE    = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h0C;

  // control: 1 = slave/adapter/server role, reset 0 = master/client
  localparam int CTRL_SLAVE_BIT = 0;

  // interrupt event bits
  localparam int EV_FAULT    = 0;
  localparam int EV_APP_ERR  = 1;
  localparam int EV_COMM_ERR = 2;
  localparam int EV_CFG_DONE = 3;
  localparam int EV_W        = 4;

  // state register bits
  localparam int ST_FAULT_LAMP   = 0;
  localparam int ST_SETUP_LAMP   = 1;
  localparam int ST_APP_LAMP     = 2;
  localparam int ST_TRAFFIC_LAMP = 3;
  localparam int ST_PORT_ERR     = 4;
  localparam int ST_APP_FLAG     = 5;
  localparam int ST_TEST_ON      = 6;
  localparam int ST_MODE_CFG     = 7;
  localparam int ST_MODE_FAULT   = 8;

  // operating mode; config mode is the all-zero code
  typedef enum logic [1:0] {
    SLI_MODE_CFG,
    SLI_MODE_RUN,
    SLI_MODE_FAULT
  } sli_mode_e;

endpackage : sli_pkg

// file: rtl/sli_blink_div.sv
`timescale 1ns/1ns
`default_nettype none
module sli_blink_div
  import sli_pkg::*;
#(
  parameter int HALF_CYC = BLINK_HALF_CYC  // cycles per flash half period
) (
  input  wire logic sys_clk,   // module clock
  input  wire logic rstn,      // synchronised reset, active low
  output var  logic blink,     // flash phase
  output var  logic halfTick   // pulse at each phase change
);

  localparam int CNT_W = $clog2(HALF_CYC);

  // refuse periods the counter cannot serve
  if (HALF_CYC < 3) begin : g_chk
    $error("HALF_CYC must be at least 3");
  end

  // whole state of the divider
  typedef struct packed {
    logic [CNT_W-1:0] cnt;   // cycles into the half period
    logic             blink; // flash phase
    logic             tick;  // phase change pulse
  } sli_div_s;

  sli_div_s st;
  sli_div_s next_st;

  always_comb begin
    next_st      = st;
    next_st.tick = 1'b0;
    if (st.cnt == CNT_W'(HALF_CYC - 1)) begin
      next_st.cnt   = '0;
      next_st.blink = ~st.blink;
      next_st.tick  = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 1'b1;
    end
  end

  // state register
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign blink    = st.blink;
  assign halfTick = st.tick;

  // ticks never closer than the period allows
  property p_tick_spacing;
    @(posedge sys_clk) disable iff (!rstn)
    halfTick |=> !halfTick [*2];
  endproperty
  a_tick_spacing: assert property (p_tick_spacing)
    else $error("flash ticks too close");

  // phase only moves with a tick
  property p_phase_tick;
    @(posedge sys_clk) disable iff (!rstn)
    $changed(blink) |-> halfTick;
  endproperty
  a_phase_tick: assert property (p_phase_tick)
    else $error("flash phase moved without tick");

endmodule : sli_blink_div
`default_nettype wire

// file: rtl/sli_lamp_top.sv
//
// Summary of operation
// - fault lamp red after critical failure, until reset
// - setup lamp amber during configuration, config download, lamp test and pass-through
// - power-up, reset button, boot command outside fault mode enter configuration
// - application lamp flashes while error flag set
// - flag clears per command or per receipt
// - recurring errors make application lamp steady
// - traffic lamp flashes green on port activity
// - port error lamp red on communication error
// - all lamps lit briefly after power-up
// - pass-through variant lights fault and setup together
// - variant failure: fault lit, setup dark
// - variant configuration: setup lit, fault dark
//
`timescale 1ns/1ns
`default_nettype none
module sli_lamp_top
  import sli_pkg::*;
#(
  parameter int       HALF_CYC           = BLINK_HALF_CYC,     // flash half period
  parameter int       STEADY_REPEATS     = APP_STEADY_REPEATS, // repeats to steady
  parameter bit       PASS_THRU_VARIANT  = 1'b1                // combined encoding
) (
  input  wire logic              sys_clk,         // module clock
  input  wire logic              resetn,          // power-up reset, active low
  input  wire logic              resetButton,     // reset push-button pulse
  input  wire logic              bootCmd,         // cold/warm boot command pulse
  input  wire logic              cfgDownload,     // config download in progress
  input  wire logic              cfgDone,         // hardware initialised pulse
  input  wire logic              criticalFault,   // program stopped pulse
  input  wire logic              debugPassThru,   // debug pass-through active
  input  wire logic              appErr,          // application error pulse
  input  wire logic              cmdStart,        // command attempt started
  input  wire logic              dataRecv,        // data received
  input  wire logic              portTx,          // serial port transmit activity
  input  wire logic              portRx,          // serial port receive activity
  input  wire logic              portCommErr,     // serial communication error
  input  wire logic [ADDR_W-1:0] regAddr,         // register byte address
  input  wire logic [DATA_W-1:0] regWrData,       // register write data
  input  wire logic              regWr,           // write strobe
  input  wire logic              regRd,           // read strobe
  output var  logic [DATA_W-1:0] regRdData,       // read data, cycle after strobe
  output var  logic              irq,             // interrupt level
  output var  logic              faultLamp,       // red fault lamp
  output var  logic              setupLamp,       // amber setup-mode lamp
  output var  logic              appErrLamp,      // red application lamp
  output var  logic              portTrafficLamp, // green port traffic lamp
  output var  logic              portErrLamp      // red port error lamp
);

  // refuse repeat counts the counter cannot hold
  if (STEADY_REPEATS < 1 || STEADY_REPEATS > 15) begin : g_chk
    $error("STEADY_REPEATS must be 1 to 15");
  end

  // whole state of the block
  typedef struct packed {
    sli_mode_e         mode;        // operating mode
    logic              roleSlave;   // selects flag clearing event
    logic              appFlag;     // application error flag
    logic [REP_W-1:0]  appRepeat;   // clears defeated in a row
    logic [HOLD_W-1:0] testCnt;     // lamp test halves elapsed
    logic [HOLD_W-1:0] trafficHold; // traffic flash remaining
    logic [HOLD_W-1:0] commHold;    // port error show remaining
    logic [EV_W-1:0]   irqStat;     // sticky events
    logic [EV_W-1:0]   irqMask;     // interrupt enables
    logic [DATA_W-1:0] rdData;      // read answer
    logic              irq;         // interrupt level
    logic              faultLamp;   // lamp drives
    logic              setupLamp;
    logic              appLamp;
    logic              trafficLamp;
    logic              portErrLamp;
  } sli_top_s;

  sli_top_s          st;          // registered state
  sli_top_s          next_st;     // next state
  logic [1:0]        rstSync;     // reset release stages
  logic              rstn;        // synchronised reset
  logic              blink;       // flash phase
  logic              halfTick;    // flash phase change
  logic              clrEv;       // flag clearing event
  logic              testOn;      // lamp test running
  logic              nextTestOn;  // lamp test running next
  logic              passOn;      // pass-through shown
  logic [EV_W-1:0]   events;      // interrupt events now
  logic [EV_W-1:0]   w1c;         // bits cleared by software

  // read mux over the register map
  function automatic logic [DATA_W-1:0] readReg(
    input logic [ADDR_W-1:0] a,
    input sli_top_s          s
  );
    logic [DATA_W-1:0] r;
    r = '0;
    unique case (a)
      ADDR_CTRL:     r[CTRL_SLAVE_BIT]  = s.roleSlave;
      ADDR_IRQ_STAT: r[EV_W-1:0]        = s.irqStat;
      ADDR_IRQ_MASK: r[EV_W-1:0]        = s.irqMask;
      ADDR_STATE: begin
        r[ST_FAULT_LAMP]   = s.faultLamp;
        r[ST_SETUP_LAMP]   = s.setupLamp;
        r[ST_APP_LAMP]     = s.appLamp;
        r[ST_TRAFFIC_LAMP] = s.trafficLamp;
        r[ST_PORT_ERR]     = s.portErrLamp;
        r[ST_APP_FLAG]     = s.appFlag;
        r[ST_TEST_ON]      = s.testCnt != LAMP_TEST_HALVES;
        r[ST_MODE_CFG]     = s.mode == SLI_MODE_CFG;
        r[ST_MODE_FAULT]   = s.mode == SLI_MODE_FAULT;
      end
      default:       r = '0;
    endcase
    return r;
  endfunction : readReg

  // reset release through two stages
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rstSync <= 2'h0;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstn = rstSync[1];

  // shared flash toggle
  sli_blink_div #(
    .HALF_CYC (HALF_CYC)
  ) u_blink (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .blink    (blink),
    .halfTick (halfTick)
  );

  // next state of the whole block
  always_comb begin
    next_st = st;
    testOn  = st.testCnt != LAMP_TEST_HALVES;
    passOn  = PASS_THRU_VARIANT && debugPassThru;
    clrEv   = st.roleSlave ? dataRecv : cmdStart;

    if (resetButton) begin
      next_st.mode = SLI_MODE_CFG;
    end else if (criticalFault) begin
      next_st.mode = SLI_MODE_FAULT;
    end else begin
      unique case (st.mode)
        // configuration until hardware ready; a boot command restarts it
        SLI_MODE_CFG:   if (cfgDone && !bootCmd) next_st.mode = SLI_MODE_RUN;
        // boot command reconfigures
        SLI_MODE_RUN:   if (bootCmd) next_st.mode = SLI_MODE_CFG;
        // stays stopped
        SLI_MODE_FAULT: next_st.mode = SLI_MODE_FAULT;
        // illegal code recovers
        default:        next_st.mode = SLI_MODE_CFG;
      endcase
    end

    if (testOn && halfTick) begin
      next_st.testCnt = st.testCnt + 3'h1;
    end
    nextTestOn = next_st.testCnt != LAMP_TEST_HALVES;

    if (clrEv && appErr) begin
      next_st.appFlag = 1'b1;
      if (st.appRepeat != '1) begin
        next_st.appRepeat = st.appRepeat + 1'b1;
      end
    end else if (clrEv) begin
      next_st.appFlag   = 1'b0;
      next_st.appRepeat = '0;
    end else if (appErr) begin
      next_st.appFlag = 1'b1;
    end

    if (portTx || portRx) begin
      next_st.trafficHold = TRAFFIC_HOLD_HALVES;
    end else if (halfTick && st.trafficHold != '0) begin
      next_st.trafficHold = st.trafficHold - 3'h1;
    end

    if (portCommErr) begin
      next_st.commHold = COMM_ERR_HOLD_HALVES;
    end else if (halfTick && st.commHold != '0) begin
      next_st.commHold = st.commHold - 3'h1;
    end

    next_st.faultLamp = nextTestOn || passOn ||
                        next_st.mode == SLI_MODE_FAULT;
    next_st.setupLamp = nextTestOn || passOn ||
                        next_st.mode == SLI_MODE_CFG ||
                        (next_st.mode == SLI_MODE_RUN && cfgDownload);
    next_st.appLamp = nextTestOn || (next_st.appFlag &&
                      (next_st.appRepeat >= REP_W'(STEADY_REPEATS) || blink));
    next_st.trafficLamp = nextTestOn || (next_st.trafficHold != '0 && blink);
    next_st.portErrLamp = nextTestOn || next_st.commHold != '0;

    // interrupt events
    events              = '0;
    events[EV_FAULT]    = criticalFault && !resetButton &&
                          st.mode != SLI_MODE_FAULT;
    events[EV_APP_ERR]  = appErr;
    events[EV_COMM_ERR] = portCommErr;
    events[EV_CFG_DONE] = cfgDone && st.mode == SLI_MODE_CFG &&
                          !resetButton && !criticalFault && !bootCmd;

    // register writes
    w1c = '0;
    if (regWr) begin
      unique case (regAddr)
        ADDR_CTRL:     next_st.roleSlave = regWrData[CTRL_SLAVE_BIT];
        ADDR_IRQ_STAT: w1c               = regWrData[EV_W-1:0];
        ADDR_IRQ_MASK: next_st.irqMask   = regWrData[EV_W-1:0];
        // unmapped and read-only writes ignored
        default:       w1c               = '0;
      endcase
    end
    // new event wins over its clear
    next_st.irqStat = (st.irqStat & ~w1c) | events;
    next_st.irq     = |(next_st.irqStat & next_st.irqMask);

    // read answer only in the cycle after the strobe
    next_st.rdData = regRd ? readReg(regAddr, st) : '0;
  end

  // state register
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from state
  assign regRdData       = st.rdData;
  assign irq             = st.irq;
  assign faultLamp       = st.faultLamp;
  assign setupLamp       = st.setupLamp;
  assign appErrLamp      = st.appLamp;
  assign portTrafficLamp = st.trafficLamp;
  assign portErrLamp     = st.portErrLamp;

  // checks share the module clock and reset
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  // failure lights fault lamp next cycle
  property p_fault_on;
    criticalFault && !resetButton |=> faultLamp;
  endproperty
  a_fault_on: assert property (p_fault_on)
    else $error("fault lamp not lit after failure");

  // fault lamp held until reset button
  property p_fault_hold;
    st.mode == SLI_MODE_FAULT && !resetButton |=> faultLamp && st.mode == SLI_MODE_FAULT;
  endproperty
  a_fault_hold: assert property (p_fault_hold)
    else $error("fault lamp dropped without reset");

  // setup lamp dark in quiet running
  property p_setup_dark;
    st.mode == SLI_MODE_RUN && !bootCmd && !resetButton && !cfgDownload &&
    !debugPassThru && !testOn |=> !setupLamp;
  endproperty
  a_setup_dark: assert property (p_setup_dark)
    else $error("setup lamp lit outside configuration");

  // restart events light the setup lamp
  property p_setup_restart;
    resetButton || (bootCmd && !criticalFault && st.mode != SLI_MODE_FAULT)
    |=> setupLamp && st.mode == SLI_MODE_CFG;
  endproperty
  a_setup_restart: assert property (p_setup_restart)
    else $error("restart did not enter configuration");

  // application lamp dark with no flag
  property p_app_dark;
    !st.appFlag && !appErr && !testOn |=> !appErrLamp;
  endproperty
  a_app_dark: assert property (p_app_dark)
    else $error("application lamp lit without error");

  // a clean clear drops the flag
  property p_flag_clear;
    clrEv && !appErr |=> !st.appFlag && st.appRepeat == '0;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("error flag not cleared");

  // persistent errors show steady
  property p_app_steady;
    st.appFlag && st.appRepeat >= REP_W'(STEADY_REPEATS) &&
    !(clrEv && !appErr) |=> appErrLamp;
  endproperty
  a_app_steady: assert property (p_app_steady)
    else $error("application lamp not steady");

  // traffic lamp dark when port idle
  property p_traffic_dark;
    st.trafficHold == '0 && !portTx && !portRx && !testOn
    |=> !portTrafficLamp;
  endproperty
  a_traffic_dark: assert property (p_traffic_dark)
    else $error("traffic lamp lit while idle");

  // activity flashes the lamp in phase
  property p_traffic_flash;
    (portTx || portRx) && blink && !halfTick |=> portTrafficLamp;
  endproperty
  a_traffic_flash: assert property (p_traffic_flash)
    else $error("traffic lamp missed activity");

  // communication error lights port lamp
  property p_port_err;
    portCommErr |=> portErrLamp;
  endproperty
  a_port_err: assert property (p_port_err)
    else $error("port error lamp not lit");

  // all lamps lit during the test
  property p_lamp_test;
    st.testCnt < LAMP_TEST_HALVES - 3'h1 |=> faultLamp && setupLamp &&
    appErrLamp && portTrafficLamp && portErrLamp;
  endproperty
  a_lamp_test: assert property (p_lamp_test)
    else $error("lamp test incomplete");

  // pass-through lights both lamps
  property p_pass_thru;
    PASS_THRU_VARIANT && debugPassThru |=> faultLamp && setupLamp;
  endproperty
  a_pass_thru: assert property (p_pass_thru)
    else $error("pass-through not shown");

  // failure shows with setup dark
  property p_fail_encode;
    PASS_THRU_VARIANT && st.mode == SLI_MODE_FAULT && !resetButton &&
    !debugPassThru && !testOn |=> faultLamp && !setupLamp;
  endproperty
  a_fail_encode: assert property (p_fail_encode)
    else $error("failure encoding wrong");

  // configuration shows with fault dark, setup lit unless hardware ready
  property p_cfg_encode;
    PASS_THRU_VARIANT && st.mode == SLI_MODE_CFG && !criticalFault &&
    !debugPassThru && !testOn |=> !faultLamp && (setupLamp || st.mode == SLI_MODE_RUN);
  endproperty
  a_cfg_encode: assert property (p_cfg_encode)
    else $error("configuration encoding wrong");

  // main scenarios
  c_fault: cover property (st.mode == SLI_MODE_RUN ##1 st.mode == SLI_MODE_FAULT);
  c_steady: cover property (st.appRepeat >= REP_W'(STEADY_REPEATS) && appErrLamp);
  c_pass: cover property (debugPassThru && faultLamp && setupLamp);
  c_traffic: cover property (portTrafficLamp && !testOn);

endmodule : sli_lamp_top
`default_nettype wire

// file: dv/sli_lamp_panel.sv
`timescale 1ns/1ns
`default_nettype none
// operator's view of the front panel: counts lamp changes since the last clear
module sli_lamp_panel (
  input  wire logic            sys_clk, // module clock
  input  wire logic            clr,     // restart the counts
  input  wire logic [4:0]      lamps,   // fault, setup, app, traffic, port error
  output var  logic [4:0][7:0] flips    // changes seen per lamp
);
  logic [4:0] seen; // lamp levels at the previous edge

  // a lamp that keeps changing reads as flashing, one that does not as steady
  always_ff @(posedge sys_clk) begin
    seen <= lamps;
    for (int i = 0; i < 5; i++) begin
      if (clr) begin
        flips[i] <= 8'h00;
      end else if (lamps[i] !== seen[i] && flips[i] != 8'hFF) begin
        flips[i] <= flips[i] + 8'h01;
      end
    end
  end
endmodule : sli_lamp_panel
`default_nettype wire

// file: dv/status_lamp_indicator_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module status_lamp_indicator_tb_top;
  import sli_pkg::*;
  localparam int LIMIT = 5000; // cycle ceiling for the whole run
  logic sys_clk, resetn, resetButton, bootCmd, cfgDownload, cfgDone, criticalFault;
  logic debugPassThru, appErr, cmdStart, dataRecv, portTx, portRx, portCommErr;
  logic              regWr, regRd, irq, clrFlips;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWrData, regRdData, rdv;
  wire logic [4:0]   lamps; // port error, traffic, app, setup, fault
  logic [4:0][7:0]   flips;
  int                fails, compares, cycles;

  sli_lamp_top #(.HALF_CYC(4), .STEADY_REPEATS(2), .PASS_THRU_VARIANT(1'b1)) dut (
    .sys_clk(sys_clk), .resetn(resetn), .resetButton(resetButton), .bootCmd(bootCmd),
    .cfgDownload(cfgDownload), .cfgDone(cfgDone), .criticalFault(criticalFault),
    .debugPassThru(debugPassThru), .appErr(appErr), .cmdStart(cmdStart),
    .dataRecv(dataRecv), .portTx(portTx), .portRx(portRx), .portCommErr(portCommErr),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .irq(irq), .faultLamp(lamps[0]), .setupLamp(lamps[1]),
    .appErrLamp(lamps[2]), .portTrafficLamp(lamps[3]), .portErrLamp(lamps[4]));

  sli_lamp_panel panel (.sys_clk(sys_clk), .clr(clrFlips), .lamps(lamps), .flips(flips));

  // free-running module clock, 100 ns period
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // hang guard
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      fails++;
      test_done();
    end
  end

  task automatic test_done();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done

  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word

  task automatic chk_lamps(input logic [4:0] exp);
    chk_word("lamps", {27'h000_0000, exp}, {27'h000_0000, lamps});
  endtask : chk_lamps

  // n edges, then settle at the falling edge
  task automatic see(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : see

  // event inputs that scenarios pulse
  typedef enum int {
    PL_CLR, PL_APP, PL_CMD, PL_RECV, PL_TX, PL_RX,
    PL_COMM, PL_CFG, PL_CRIT, PL_BOOT, PL_BUTTON
  } sli_pulse_e;

  // set one event input to a level
  task automatic drive(input sli_pulse_e which, input logic v);
    case (which)
      PL_CLR:    clrFlips      <= v;
      PL_APP:    appErr        <= v;
      PL_CMD:    cmdStart      <= v;
      PL_RECV:   dataRecv      <= v;
      PL_TX:     portTx        <= v;
      PL_RX:     portRx        <= v;
      PL_COMM:   portCommErr   <= v;
      PL_CFG:    cfgDone       <= v;
      PL_CRIT:   criticalFault <= v;
      PL_BOOT:   bootCmd       <= v;
      default:   resetButton   <= v;
    endcase
  endtask : drive

  // one-cycle pulse on an event input
  task automatic pulse(input sli_pulse_e which);
    @(posedge sys_clk);
    drive(which, 1'b1);
    @(posedge sys_clk);
    drive(which, 1'b0);
  endtask : pulse

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    @(negedge sys_clk);
    d = regRdData;
  endtask : rd

  task automatic t_power();
    see(6);
    chk_lamps(5'h1F);
    see(30);
    chk_lamps(5'h02);
    $display("test power done");
  endtask : t_power

  task automatic t_irq();
    pulse(PL_CFG);
    see(0);
    chk_lamps(5'h00);
    rd(ADDR_IRQ_STAT, rdv);
    chk_word("irq stat", 32'h0000_0008, rdv);
    rd(8'h10, rdv);
    chk_word("unmapped", 32'h0000_0000, rdv);
    wr(ADDR_STATE, 32'hFFFF_FFFF);
    rd(ADDR_STATE, rdv);
    chk_word("state", 32'h0000_0000, rdv);
    wr(ADDR_IRQ_MASK, 32'h0000_0008);
    see(1);
    chk_word("irq on", 32'h1, {31'h0, irq});
    wr(ADDR_IRQ_STAT, 32'h0000_0008);
    see(1);
    chk_word("irq off", 32'h0, {31'h0, irq});
    $display("test irq done");
  endtask : t_irq

  task automatic t_app();
    pulse(PL_CLR);
    pulse(PL_APP);
    see(24);
    chk_word("app flash", 32'h1, {31'h0, flips[2] >= 8'h04});
    chk_word("masked irq", 32'h0, {31'h0, irq});
    pulse(PL_CMD);
    see(1);
    chk_lamps(5'h00);
    wr(ADDR_CTRL, 32'h0000_0001);
    pulse(PL_APP);
    pulse(PL_CMD);
    rd(ADDR_STATE, rdv);
    chk_word("slave flag", 32'h0000_0020, rdv & 32'h0000_0020);
    pulse(PL_RECV);
    rd(ADDR_STATE, rdv);
    chk_word("slave clr", 32'h0000_0000, rdv & 32'h0000_0020);
    wr(ADDR_CTRL, 32'h0000_0000);
    $display("test app done");
  endtask : t_app

  task automatic t_steady();
    pulse(PL_APP);
    @(posedge sys_clk);
    appErr <= 1'b1;
    cmdStart <= 1'b1;
    repeat (2) @(posedge sys_clk);
    appErr <= 1'b0;
    cmdStart <= 1'b0;
    see(2);
    pulse(PL_CLR);
    see(16);
    chk_lamps(5'h04);
    chk_word("steady", 32'h0, {24'h00_0000, flips[2]});
    pulse(PL_CMD);
    see(1);
    chk_lamps(5'h00);
    $display("test steady done");
  endtask : t_steady

  task automatic t_port();
    pulse(PL_CLR);
    pulse(PL_TX);
    see(14);
    chk_word("tx flash", 32'h1, {31'h0, flips[3] >= 8'h01});
    see(10);
    chk_lamps(5'h00);
    pulse(PL_CLR);
    pulse(PL_RX);
    see(14);
    chk_word("rx flash", 32'h1, {31'h0, flips[3] >= 8'h01});
    see(10);
    pulse(PL_COMM);
    see(0);
    chk_lamps(5'h10);
    see(20);
    chk_lamps(5'h00);
    $display("test port done");
  endtask : t_port

  task automatic t_pass();
    @(posedge sys_clk);
    cfgDownload <= 1'b1;
    see(1);
    chk_lamps(5'h02);
    @(posedge sys_clk);
    cfgDownload <= 1'b0;
    debugPassThru <= 1'b1;
    see(1);
    chk_lamps(5'h03);
    @(posedge sys_clk);
    debugPassThru <= 1'b0;
    see(1);
    chk_lamps(5'h00);
    $display("test pass done");
  endtask : t_pass

  task automatic t_fault();
    pulse(PL_CRIT);
    see(0);
    chk_lamps(5'h01);
    pulse(PL_BOOT);
    see(4);
    chk_lamps(5'h01);
    pulse(PL_BUTTON);
    see(0);
    chk_lamps(5'h02);
    pulse(PL_CFG);
    see(0);
    chk_lamps(5'h00);
    pulse(PL_BOOT);
    see(0);
    chk_lamps(5'h02);
    $display("test fault done");
  endtask : t_fault

  // main sequence
  initial begin
    {resetn, resetButton, bootCmd, cfgDownload, cfgDone, criticalFault} = 6'h00;
    {debugPassThru, appErr, cmdStart, dataRecv, portTx, portRx, portCommErr} = 7'h00;
    {regWr, regRd, clrFlips} = 3'h0;
    regAddr = 8'h00;
    regWrData = 32'h0000_0000;
    fails = 0;
    compares = 0;
    cycles = 0;
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    t_power();
    t_irq();
    t_app();
    t_steady();
    t_port();
    t_pass();
    t_fault();
    test_done();
  end
endmodule : status_lamp_indicator_tb_top
`default_nettype wire
